/* fsc_ctrl.sv */
// operating-state controller: idle, diagnostics, normal, fault, disabled
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.svh"
module fsc_ctrl
  import fsc_pkg::*;
(
  // clock and reset
  input  wire logic                     clk,
  input  wire logic                     rst,
  // supply monitors, asynchronous
  input  wire logic                     supply_ok,
  input  wire logic                     regulated_supply_uv,
  input  wire logic                     digital_supply_uv,
  // power-on reset sequencing
  input  wire logic                     por_done,
  // diagnostics progress
  input  wire logic                     checks_done,
  input  wire logic                     checks_pass,
  // initialization faults, asynchronous
  input  wire logic                     memory_checksum_err,
  input  wire logic                     logic_self_test_err,
  input  wire logic                     monitor_self_test_err,
  input  wire logic                     sensor_if_self_test_err,
  input  wire logic                     reg_cap_loss_err,
  input  wire logic                     gain_select_pin_test_err,
  // run-time recoverable faults, asynchronous
  input  wire logic                     regulated_supply_ov,
  input  wire logic                     out_mismatch_err,
  // run-time critical faults, asynchronous
  input  wire logic                     reg_checksum_err,
  input  wire logic                     redundancy_err,
  input  wire logic                     test_mode_pin_err,
  input  wire logic                     test_output_pin_err,
  input  wire logic                     gain_select_pin_toggle,
  // any other non-forcing fault seen in fault state
  input  wire logic                     other_fault,
  // block enables
  output logic                          por_req,
  output logic                          osc_en,
  output logic                          analog_front_end_en,
  output logic                          gain_control_path_en,
  output logic                          monitor_en,
  // sensor output stage, tri-state
  input  wire logic [`FSC_NUM_OUT-1:0]  out_level,
  output logic [`FSC_NUM_OUT-1:0]       sensor_output_pins_o,
  output logic [`FSC_NUM_OUT-1:0]       sensor_output_pins_oe,
  // status
  output var  logic [2:0]               state_o,
  output var  logic                     retry_exhausted
);

  ////////////////////////////////////////////////////////////////////////////
  // input synchronisation
  localparam int NF = 16;
  logic [NF-1:0] raw_in;
  logic [NF-1:0] syn;

  assign raw_in = {supply_ok, regulated_supply_uv, digital_supply_uv,
                   memory_checksum_err, logic_self_test_err, monitor_self_test_err,
                   sensor_if_self_test_err, reg_cap_loss_err, gain_select_pin_test_err,
                   regulated_supply_ov, out_mismatch_err, reg_checksum_err,
                   redundancy_err, test_mode_pin_err, test_output_pin_err,
                   gain_select_pin_toggle};

  fsc_sync #(.W(NF)) u_sync (
    .clk (clk),
    .rst (rst),
    .d   (raw_in),
    .q   (syn)
  );

  logic s_ok;
  logic s_uv;
  logic s_crc;
  logic s_init;
  logic s_ov;
  logic s_rec;
  logic s_crit;
  logic s_red;

  assign s_ok   = syn[15];
  assign s_uv   = syn[14] | syn[13];
  assign s_crc  = syn[12];
  assign s_init = |syn[12:7];
  assign s_ov   = syn[6];
  assign s_rec  = syn[6] | syn[5];
  assign s_red  = syn[3];
  assign s_crit = syn[4] | syn[3] | syn[2] | syn[1] | syn[0];

  ////////////////////////////////////////////////////////////////////////////
  // state register
  fsc_state_t state_r;
  fsc_state_t state_nxt;
  logic [`FSC_WAIT_W-1:0]  wait_r;
  logic [`FSC_RETRY_W-1:0] crc_retry_r;
  logic                    crc_cause_r;
  logic                    wait_done;
  logic                    crc_blocked;

  assign wait_done   = (wait_r == `FSC_WAIT_W'(`FSC_DIS_WAIT_CYC - 1));
  assign crc_blocked = crc_cause_r &&
                       (crc_retry_r == `FSC_RETRY_W'(`FSC_CRC_RETRY_MAX));

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      FSC_IDLE: begin
        if (s_ok && !s_uv && por_done) begin
          state_nxt = FSC_DIAG;
        end
      end
      FSC_DIAG: begin
        if (s_init || s_red || s_crit) begin
          state_nxt = FSC_DISABLED;
        end else if (s_rec) begin
          state_nxt = FSC_FAULT;
        end else if (checks_done && checks_pass) begin
          state_nxt = FSC_NORMAL;
        end
      end
      FSC_NORMAL: begin
        if (s_crit) begin
          state_nxt = FSC_DISABLED;
        end else if (s_rec) begin
          state_nxt = FSC_FAULT;
        end
      end
      FSC_FAULT: begin
        if (s_crit) begin
          state_nxt = FSC_DISABLED;
        end else if (s_ov) begin
          state_nxt = FSC_FAULT;
        end else begin
          state_nxt = FSC_DIAG;
        end
      end
      FSC_DISABLED: begin
        if (wait_done && !crc_blocked) begin
          state_nxt = FSC_DIAG;
        end
      end
      default: begin
        state_nxt = FSC_IDLE;
      end
    endcase
  end

  // undervoltage or reset forces idle; power cycle restarts from idle
  always_ff @(posedge clk) begin
    if (rst) begin
      state_r <= FSC_IDLE;
    end else if (s_uv || !s_ok) begin
      state_r <= FSC_IDLE;
    end else begin
      state_r <= state_nxt;
    end
  end

  // dwell counter for the disabled state
  always_ff @(posedge clk) begin
    if (rst) begin
      wait_r <= '0;
    end else if (state_r != FSC_DISABLED) begin
      wait_r <= '0;
    end else if (!wait_done) begin
      wait_r <= wait_r + `FSC_WAIT_W'(1);
    end
  end

  // latch whether the last disable came from the memory checksum
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_cause_r <= 1'b0;
    end else if (state_r != FSC_DISABLED && state_nxt == FSC_DISABLED && !s_uv && s_ok) begin
      crc_cause_r <= s_crc;
    end
  end

  // survives undervoltage restarts on purpose: only a full reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      crc_retry_r <= '0;
    end else if (state_r == FSC_DISABLED && state_nxt == FSC_DIAG && crc_cause_r &&
                 !s_uv && s_ok &&
                 crc_retry_r != `FSC_RETRY_W'(`FSC_CRC_RETRY_MAX)) begin
      crc_retry_r <= crc_retry_r + `FSC_RETRY_W'(1);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // enables decoded from the registered state; output enable in diagnostics also needs checks_done and checks_pass
  logic drive_ok;

  assign drive_ok             = (state_r == FSC_NORMAL) ||
                                (state_r == FSC_DIAG && checks_done && checks_pass);
  assign por_req              = (state_r == FSC_IDLE);
  assign osc_en               = (state_r == FSC_NORMAL) || (state_r == FSC_DIAG);
  assign analog_front_end_en  = (state_r == FSC_NORMAL) || (state_r == FSC_DIAG);
  assign gain_control_path_en = (state_r == FSC_NORMAL) || (state_r == FSC_DIAG);
  assign monitor_en           = (state_r == FSC_NORMAL) || (state_r == FSC_FAULT);
  assign sensor_output_pins_oe = {`FSC_NUM_OUT{drive_ok}};

  // output data comes from flops; undriven while the enable is low
  always_ff @(posedge clk) begin
    if (rst) begin
      sensor_output_pins_o <= '0;
    end else begin
      sensor_output_pins_o <= out_level;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      state_o         <= 3'h0;
      retry_exhausted <= 1'b0;
    end else begin
      state_o         <= state_r;
      retry_exhausted <= crc_blocked;
    end
  end

endmodule : fsc_ctrl
`default_nettype wire

/* fsc_regs.svh */
// constants for the operating-state controller
`ifndef FSC_REGS_SVH
`define FSC_REGS_SVH
`define FSC_CLK_HZ          200000000
`define FSC_DIS_WAIT_MS     20
`define FSC_DIS_WAIT_CYC    ((`FSC_CLK_HZ / 1000) * `FSC_DIS_WAIT_MS)
`define FSC_CRC_RETRY_MAX   3
`define FSC_RETRY_W         2
`define FSC_WAIT_W          23
`define FSC_NUM_OUT         4
`endif

/* fsc_pkg.sv */
// types for the operating-state controller
package fsc_pkg;
  typedef enum logic [2:0] {
    FSC_IDLE     = 3'b000,
    FSC_DIAG     = 3'b001,
    FSC_NORMAL   = 3'b010,
    FSC_FAULT    = 3'b011,
    FSC_DISABLED = 3'b100
  } fsc_state_t;
endpackage : fsc_pkg

/* fsc_sync.sv */
// two-flop synchroniser for asynchronous fault and supply inputs
`timescale 1ns/1ps
`default_nettype none
module fsc_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         clk,
  input  wire logic         rst,
  // data
  input  wire logic [W-1:0] d,
  output var  logic [W-1:0] q
);
  logic [W-1:0] meta_r;

  always_ff @(posedge clk) begin
    if (rst) begin
      meta_r <= '0;
      q      <= '0;
    end else begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : fsc_sync
`default_nettype wire

/* fsc_ctrl_assertions.sv */
// checker for the operating-state controller ports
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.svh"
module fsc_ctrl_chk (
  // clock and reset
  input wire logic                    clk,
  input wire logic                    rst,
  // watched inputs
  input wire logic                    supply_ok,
  input wire logic                    regulated_supply_uv,
  input wire logic                    regulated_supply_ov,
  input wire logic                    checks_done,
  input wire logic                    checks_pass,
  // watched outputs
  input wire logic                    por_req,
  input wire logic                    osc_en,
  input wire logic                    analog_front_end_en,
  input wire logic                    gain_control_path_en,
  input wire logic                    monitor_en,
  input wire logic [`FSC_NUM_OUT-1:0] sensor_output_pins_oe,
  input wire logic                    retry_exhausted
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////////
  idle_safe_a: assert property (por_req |-> !(|sensor_output_pins_oe) && !osc_en && !monitor_en)
    else $error("idle drives outputs");
  fault_safe_a: assert property (monitor_en && !osc_en |-> !analog_front_end_en && !(|sensor_output_pins_oe))
    else $error("fault state drives outputs");
  out_gated_a: assert property (|sensor_output_pins_oe && !monitor_en |-> checks_done && checks_pass && osc_en)
    else $error("outputs driven before checks finish");
  path_enables_a: assert property (osc_en == analog_front_end_en && osc_en == gain_control_path_en)
    else $error("signal path enables disagree");
  uv_reset_a: assert property (regulated_supply_uv [*6] |-> por_req && !(|sensor_output_pins_oe))
    else $error("undervoltage not holding reset");
  // a critical fault may still take fault on to disabled; a retry to diagnostics and a drop to idle are barred
  ov_hold_a: assert property (regulated_supply_ov [*4] ##0 (monitor_en && !osc_en && supply_ok && !regulated_supply_uv) |=> !osc_en && !por_req)
    else $error("left fault while overvoltage held");
  fault_retry_a: assert property (not ((monitor_en && !osc_en && !regulated_supply_ov) [*6]))
    else $error("fault state did not retry");
  reset_clear_a: assert property ($past(rst) |-> por_req && !retry_exhausted)
    else $error("power cycle did not restart cleanly");
endmodule : fsc_ctrl_chk
bind fsc_ctrl fsc_ctrl_chk u_chk (.clk, .rst, .supply_ok, .regulated_supply_uv, .regulated_supply_ov,
  .checks_done, .checks_pass, .por_req, .osc_en, .analog_front_end_en, .gain_control_path_en,
  .monitor_en, .sensor_output_pins_oe, .retry_exhausted);
`default_nettype wire

/* fsc_host.sv */
// host model: resolves the sensor pins through its pull resistors
`timescale 1ns/1ps
`default_nettype none
`include "fsc_regs.svh"
module fsc_host #(
  parameter logic [`FSC_NUM_OUT-1:0] PULL = 4'hA
) (
  // pin drive from the block
  input  wire logic [`FSC_NUM_OUT-1:0] pin_o,
  input  wire logic [`FSC_NUM_OUT-1:0] pin_oe,
  // what the converters see
  output logic [`FSC_NUM_OUT-1:0]      level,
  output logic                         fault_seen
);
  // a released pin shows the pull level, never the last driven value
  always_comb begin
    for (int i = 0; i < `FSC_NUM_OUT; i++) begin
      level[i] = pin_oe[i] ? pin_o[i] : PULL[i];
    end
  end
  assign fault_seen = (pin_oe != 4'hF);
endmodule : fsc_host
`default_nettype wire

/* test_fault_state_controller.sv */
// self-checking bench for the operating-state controller
`timescale 1ns/1ps
`default_nettype none
module test_fault_state_controller import fsc_pkg::*; ;
  localparam logic [3:0] PULL = 4'hA;
  logic       clk, rst, supply_ok, por_done, checks_done, checks_pass, fseen;
  logic       regulated_supply_ov, out_mismatch_err, por_req, osc_en, monitor_en;
  logic       analog_front_end_en, gain_control_path_en, retry_exhausted;
  logic [1:0] uv;
  logic [5:0] initf;
  logic [4:0] critf;
  logic [3:0] out_level, pin_o, pin_oe, level;
  logic [2:0] state_o;
  int         n_mismatch, cmp_count, cyc;
  fsc_ctrl dut (.clk, .rst, .supply_ok, .por_done, .checks_done, .checks_pass,
    .regulated_supply_uv(uv[0]), .digital_supply_uv(uv[1]), .memory_checksum_err(initf[0]),
    .logic_self_test_err(initf[1]), .monitor_self_test_err(initf[2]),
    .sensor_if_self_test_err(initf[3]), .reg_cap_loss_err(initf[4]),
    .gain_select_pin_test_err(initf[5]), .regulated_supply_ov, .out_mismatch_err,
    .reg_checksum_err(critf[0]), .redundancy_err(critf[1]), .test_mode_pin_err(critf[2]),
    .test_output_pin_err(critf[3]), .gain_select_pin_toggle(critf[4]), .other_fault(1'b0),
    .por_req, .osc_en, .analog_front_end_en, .gain_control_path_en, .monitor_en, .out_level,
    .sensor_output_pins_o(pin_o), .sensor_output_pins_oe(pin_oe), .state_o, .retry_exhausted);
  fsc_host #(.PULL(PULL)) host (.pin_o, .pin_oe, .level, .fault_seen(fseen));
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // generous ceiling; the disable wait itself is never run out here
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      n_mismatch++;
      results();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : tick
  task chk(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task wst(input logic [2:0] e);
    int i;
    i = 0;
    while (i < 40 && state_o !== e) begin
      tick(1);
      i++;
    end
    chk(state_o, e);
  endtask : wst
  task pwr;
    rst = 1'b1;
    {uv, initf, critf, regulated_supply_ov, out_mismatch_err, checks_done, checks_pass} = '0;
    tick(4);
    chk(state_o, FSC_IDLE);
    rst = 1'b0;
    wst(FSC_DIAG);
  endtask : pwr
  task norm;
    checks_done = 1'b1;
    checks_pass = 1'b1;
    wst(FSC_NORMAL);
  endtask : norm
  ////////////////////////////////////////////////////////////////////////////////
  task t_boot;
    pwr();
    tick(10);
    chk(level, PULL);
    norm();
    chk({osc_en, analog_front_end_en, gain_control_path_en, monitor_en}, 4'hF);
    chk(retry_exhausted, 1'b0);
    out_level = 4'h5;
    tick(3);
    chk(level, 4'h5);
    $display("boot test done");
  endtask : t_boot
  task t_run;
    // a non-forcing fault bounces between fault and diagnostics each cycle
    out_mismatch_err = 1'b1;
    wst(FSC_FAULT);
    out_mismatch_err = 1'b0;
    wst(FSC_NORMAL);
    regulated_supply_ov = 1'b1;
    wst(FSC_FAULT);
    chk({osc_en, analog_front_end_en, fseen, level}, {3'h1, PULL});
    tick(30);
    chk(state_o, FSC_FAULT);
    regulated_supply_ov = 1'b0;
    wst(FSC_NORMAL);
    regulated_supply_ov = 1'b1;
    wst(FSC_FAULT);
    critf[2] = 1'b1;
    wst(FSC_DISABLED);
    chk(level, PULL);
    $display("run-time fault test done");
  endtask : t_run
  task t_faults;
    for (int i = 0; i < 6; i++) begin
      pwr();
      initf[i] = 1'b1;
      wst(FSC_DISABLED);
    end
    for (int i = 0; i < 5; i++) begin
      pwr();
      norm();
      critf[i] = 1'b1;
      tick(6);
      chk(state_o, FSC_DISABLED);
    end
    $display("init and critical fault test done");
  endtask : t_faults
  task t_uv;
    for (int i = 0; i < 2; i++) begin
      pwr();
      norm();
      uv[i] = 1'b1;
      wst(FSC_IDLE);
      tick(20);
      chk({state_o, level}, {FSC_IDLE, PULL});
      uv[i] = 1'b0;
      wst(FSC_NORMAL);
    end
    $display("undervoltage test done");
  endtask : t_uv
  task results;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  initial begin
    {rst, uv, initf, critf, regulated_supply_ov, out_mismatch_err} = {1'b1, 15'h0};
    {supply_ok, por_done, checks_done, checks_pass, out_level} = {4'hC, 4'h0};
    tick(1);
    t_boot();
    t_run();
    t_faults();
    t_uv();
    results();
  end
endmodule : test_fault_state_controller
`default_nettype wire
